// ### verilog/tpg_regs.vh
// Register indices, field positions and reset values of the test pattern unit.
`ifndef TPG_REGS_VH
`define TPG_REGS_VH

// Register indices within the serial parameter category.
`define TPG_IDX_ENABLE_GAIN   8'h24
`define TPG_IDX_SELECT_CTRL   8'h25
`define TPG_IDX_CR_LEVEL_S2   8'h27
`define TPG_IDX_CR_LEVEL_S1   8'h28
`define TPG_IDX_CB_LEVEL_S2   8'h29
`define TPG_IDX_CB_LEVEL_S1   8'h2A

// Field positions in pattern_enable_gain.
`define TPG_ENABLE_BIT        3
`define TPG_GAIN_LSB          6

// Field positions in pattern_select_control.
`define TPG_TYPE_LSB          0
`define TPG_ORIENT_BIT        2
`define TPG_RAMP_BIT          3
`define TPG_SPLIT_BIT         4
`define TPG_COLOUR_LSB        5

// Pattern type codes.
`define TPG_PAT_COLOUR_BAR    2'h0
`define TPG_PAT_RASTER        2'h1
`define TPG_PAT_IMPULSE       2'h2
`define TPG_PAT_SERIAL        2'h3
`define TPG_COLOUR_RAMP       3'h7

// Reset values.
`define TPG_RST_ENABLE_GAIN   8'h40
`define TPG_RST_SELECT_CTRL   8'h00
`define TPG_RST_LEVEL         8'h80

// Active frame geometry.
`define TPG_ACTIVE_W          11'h2D0
`define TPG_ACTIVE_H          10'h1E0

`endif

// ### verilog/tpg_colour_rom.v
// Fixed chroma line levels for the raster and bar colours.
`timescale 1ns/1ps
`default_nettype none

module tpg_colour_rom (
    // Colour code, 0 to 7; code 7 gives 10h on all four levels
    input  wire [2:0] colour,
    // Four levels: cr_s2, cr_s1, cb_s2, cb_s1
    output reg  [7:0] cr_s2,
    output reg  [7:0] cr_s1,
    output reg  [7:0] cb_s2,
    output reg  [7:0] cb_s1
);

    always @* begin
        case (colour)
            3'h0: begin cr_s2 = 8'h80; cr_s1 = 8'h60; cb_s2 = 8'h60; cb_s1 = 8'h80; end
            3'h1: begin cr_s2 = 8'h60; cr_s1 = 8'h40; cb_s2 = 8'h60; cb_s1 = 8'h40; end
            3'h2: begin cr_s2 = 8'h40; cr_s1 = 8'h60; cb_s2 = 8'h40; cb_s1 = 8'h60; end
            3'h3: begin cr_s2 = 8'h20; cr_s1 = 8'h40; cb_s2 = 8'h40; cb_s1 = 8'h20; end
            3'h4: begin cr_s2 = 8'h60; cr_s1 = 8'h20; cb_s2 = 8'h20; cb_s1 = 8'h60; end
            3'h5: begin cr_s2 = 8'h40; cr_s1 = 8'h00; cb_s2 = 8'h20; cb_s1 = 8'h20; end
            3'h6: begin cr_s2 = 8'h20; cr_s1 = 8'h20; cb_s2 = 8'h00; cb_s1 = 8'h40; end
            default: begin cr_s2 = 8'h10; cr_s1 = 8'h10; cb_s2 = 8'h10; cb_s1 = 8'h10; end
        endcase
    end

endmodule // tpg_colour_rom

`default_nettype wire

// ### verilog/tpg_test_pattern_unit.v
// Test pattern unit: serial parameter bytes, pattern synthesis and output select.
`timescale 1ns/1ps
`default_nettype none

`include "tpg_regs.vh"

// What this block does
// [R1] Enable bit 1 outputs the test pattern; 0 passes normal video.
// [R2] Gain code 0 gives zero, 1 unity, 2 doubled, 3 quadrupled.
// [R3] Type field picks colour bar, raster, impulse or serial chroma pattern.
// [R4] Raster colour codes 0 to 6 give W, Ye, Cy, G, Mg, R, B.
// [R5] Raster colour code 7 gives a horizontal ramp, overriding other selections; here split and gain still apply.
// [R6] Ramp-add superimposes a ramp; on impulse it inverts the display instead.
// [R7] Ramp-add has no effect on the serially programmed pattern.
// [R8] Orientation 0 lays the pattern out horizontally, 1 vertically.
// [R9] The added ramp always runs perpendicular to the pattern.
// [R10] Split bit 1 shares the screen between pattern and live image.
// [R11] Four independent 8-bit chroma line levels feed the serial pattern.
// [R12] Software should program near-ideal levels, e.g. white 80h 60h 60h 80h.
// [R13] Software sets the auto control hold bit before configuring the generator.
// [R14] Software loads matrix, hue, mode and white balance presets beforehand.
// [R15] One sample per pixel clock, located by active horizontal and vertical counters.
module tpg_test_pattern_unit (
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // Serial parameter write and read port
    input  wire        param_wr,
    input  wire [7:0]  param_index,
    input  wire [7:0]  param_wdata,
    output reg  [7:0]  param_rdata,
    // Video timing from the processor
    input  wire        line_start,
    input  wire        frame_start,
    input  wire        active,
    // Live video in
    input  wire [7:0]  live_luma,
    input  wire [7:0]  live_chroma,
    // Video out
    output reg  [7:0]  out_luma,
    output reg  [7:0]  out_chroma,
    output reg         pattern_area
);

    reg  [7:0]  enable_gain_q;
    reg  [7:0]  select_ctrl_q;
    reg  [7:0]  cr_level_s2_q;
    reg  [7:0]  cr_level_s1_q;
    reg  [7:0]  cb_level_s2_q;
    reg  [7:0]  cb_level_s1_q;
    reg  [10:0] hcount_q;
    reg  [9:0]  vcount_q;
    reg         phase_q;
    reg         line_q;

    wire        pattern_display_enable = enable_gain_q[`TPG_ENABLE_BIT];
    wire [1:0]  pattern_gain_select    = enable_gain_q[`TPG_GAIN_LSB +: 2];
    wire [1:0]  pattern_type_select    = select_ctrl_q[`TPG_TYPE_LSB +: 2];
    wire        pattern_orientation    = select_ctrl_q[`TPG_ORIENT_BIT];
    wire        ramp_overlay_enable    = select_ctrl_q[`TPG_RAMP_BIT];
    wire        live_image_split       = select_ctrl_q[`TPG_SPLIT_BIT];
    wire [2:0]  raster_colour_select   = select_ctrl_q[`TPG_COLOUR_LSB +: 3];

    // Parameter bytes. Unlisted indices are ignored on write and read zero.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_gain_q <= `TPG_RST_ENABLE_GAIN;
            select_ctrl_q <= `TPG_RST_SELECT_CTRL;
            cr_level_s2_q <= `TPG_RST_LEVEL;
            cr_level_s1_q <= `TPG_RST_LEVEL;
            cb_level_s2_q <= `TPG_RST_LEVEL;
            cb_level_s1_q <= `TPG_RST_LEVEL;
        end else if (param_wr) begin
            case (param_index)
                `TPG_IDX_ENABLE_GAIN: enable_gain_q <= param_wdata;
                `TPG_IDX_SELECT_CTRL: select_ctrl_q <= param_wdata;
                `TPG_IDX_CR_LEVEL_S2: cr_level_s2_q <= param_wdata; // [R11]
                `TPG_IDX_CR_LEVEL_S1: cr_level_s1_q <= param_wdata; // [R11]
                `TPG_IDX_CB_LEVEL_S2: cb_level_s2_q <= param_wdata; // [R11]
                `TPG_IDX_CB_LEVEL_S1: cb_level_s1_q <= param_wdata; // [R11]
                default: ;
            endcase
        end
    end

    always @* begin
        case (param_index)
            `TPG_IDX_ENABLE_GAIN: param_rdata = enable_gain_q;
            `TPG_IDX_SELECT_CTRL: param_rdata = select_ctrl_q;
            `TPG_IDX_CR_LEVEL_S2: param_rdata = cr_level_s2_q;
            `TPG_IDX_CR_LEVEL_S1: param_rdata = cr_level_s1_q;
            `TPG_IDX_CB_LEVEL_S2: param_rdata = cb_level_s2_q;
            `TPG_IDX_CB_LEVEL_S1: param_rdata = cb_level_s1_q;
            default:              param_rdata = 8'h00;
        endcase
    end

    // Active-video position counters; phase alternates per pixel, line per row.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hcount_q <= 11'h000;
            vcount_q <= 10'h000;
            phase_q  <= 1'b0;
            line_q   <= 1'b0;
        end else begin
            if (frame_start) begin
                vcount_q <= 10'h000;
                line_q   <= 1'b0;
            end else if (line_start) begin
                vcount_q <= vcount_q + 10'h001; // [R15]
                line_q   <= ~line_q;
            end
            if (line_start || frame_start) begin
                hcount_q <= 11'h000;
                phase_q  <= 1'b0;
            end else if (active) begin
                hcount_q <= hcount_q + 11'h001; // [R15]
                phase_q  <= ~phase_q;
            end
        end
    end

    // Pattern axis follows orientation; ramp axis is always the other one.
    wire [10:0] vcount_w   = {1'b0, vcount_q};
    wire [10:0] pat_pos    = pattern_orientation ? vcount_w : hcount_q; // [R8]
    wire [10:0] pat_span   = pattern_orientation ? {1'b0, `TPG_ACTIVE_H} : `TPG_ACTIVE_W;
    wire [10:0] ramp_pos   = pattern_orientation ? hcount_q : vcount_w; // [R9]
    wire [10:0] ramp_span  = pattern_orientation ? `TPG_ACTIVE_W : {1'b0, `TPG_ACTIVE_H};

    // Eight bars across the pattern axis; index 7 is black.
    wire [13:0] bar_prod   = {pat_pos, 3'h0};
    wire [2:0]  bar_index  = (bar_prod >= {3'h0, pat_span} * 14'h0007) ? 3'h7 :
                             (bar_prod >= {3'h0, pat_span} * 14'h0006) ? 3'h6 :
                             (bar_prod >= {3'h0, pat_span} * 14'h0005) ? 3'h5 :
                             (bar_prod >= {3'h0, pat_span} * 14'h0004) ? 3'h4 :
                             (bar_prod >= {3'h0, pat_span} * 14'h0003) ? 3'h3 :
                             (bar_prod >= {3'h0, pat_span} * 14'h0002) ? 3'h2 :
                             (bar_prod >= {3'h0, pat_span}) ? 3'h1 : 3'h0;
    // Ramp value: position scaled to 8 bits over a 1024-step axis, or a 512-step axis where the ramp span is 512 or less.
    wire [7:0]  hramp      = hcount_q[9:2];
    wire [7:0]  xramp      = (ramp_span > 11'h200) ? ramp_pos[9:2] : ramp_pos[8:1];

    wire [2:0]  rom_colour = (pattern_type_select == `TPG_PAT_COLOUR_BAR) ? bar_index
                                                                          : raster_colour_select; // [R4]
    wire [7:0]  rom_cr_s2;
    wire [7:0]  rom_cr_s1;
    wire [7:0]  rom_cb_s2;
    wire [7:0]  rom_cb_s1;

    tpg_colour_rom u_rom (
        .colour (rom_colour),
        .cr_s2  (rom_cr_s2),
        .cr_s1  (rom_cr_s1),
        .cb_s2  (rom_cb_s2),
        .cb_s1  (rom_cb_s1)
    );

    // Luma is the mean of the CR S2 and CB S1 levels; chroma picks CR or CB by line and S2 or S1 by pixel phase.
    reg  [7:0]  pat_luma;
    reg  [7:0]  pat_chroma;
    reg  [8:0]  luma_sum;
    reg  [8:0]  ramp_sum;
    wire        impulse    = (pat_pos[5:0] == 6'h00);

    always @* begin
        pat_luma   = 8'h00;
        pat_chroma = 8'h80;
        luma_sum   = 9'h000;
        ramp_sum   = 9'h000;
        if (raster_colour_select == `TPG_COLOUR_RAMP) begin
            pat_luma = hramp; // [R5]
        end else begin
            case (pattern_type_select) // [R3]
                `TPG_PAT_COLOUR_BAR, `TPG_PAT_RASTER: begin
                    luma_sum   = {1'b0, rom_cr_s2} + {1'b0, rom_cb_s1};
                    pat_luma   = luma_sum[8:1];
                    pat_chroma = line_q ? (phase_q ? rom_cb_s1 : rom_cb_s2)
                                        : (phase_q ? rom_cr_s1 : rom_cr_s2);
                end
                `TPG_PAT_IMPULSE: begin
                    pat_luma = impulse ? 8'hFF : 8'h00;
                    if (ramp_overlay_enable) begin
                        pat_luma = ~pat_luma; // [R6]
                    end
                end
                `TPG_PAT_SERIAL: begin
                    luma_sum   = {1'b0, cr_level_s2_q} + {1'b0, cb_level_s1_q};
                    pat_luma   = luma_sum[8:1];
                    pat_chroma = line_q ? (phase_q ? cb_level_s1_q : cb_level_s2_q)
                                        : (phase_q ? cr_level_s1_q : cr_level_s2_q); // [R11]
                end
                default: ;
            endcase
            // The serial pattern never takes a ramp.
            if (ramp_overlay_enable && pattern_type_select != `TPG_PAT_IMPULSE
                && pattern_type_select != `TPG_PAT_SERIAL) begin // [R7]
                ramp_sum = {1'b0, pat_luma[7:1]} + {1'b0, xramp[7:1]}; // [R6] [R9]
                pat_luma = ramp_sum[8] ? 8'hFF : ramp_sum[7:0];
            end
        end
    end

    // Gain saturates rather than wrapping so bright bars stay white.
    reg  [9:0]  gain_luma;
    always @* begin
        case (pattern_gain_select) // [R2]
            2'h0:    gain_luma = 10'h000;
            2'h1:    gain_luma = {2'h0, pat_luma};
            2'h2:    gain_luma = {1'h0, pat_luma, 1'h0};
            2'h3:    gain_luma = {pat_luma, 2'h0};
            default: gain_luma = 10'h000;
        endcase
    end
    wire [7:0]  gained     = (gain_luma[9:8] != 2'h0) ? 8'hFF : gain_luma[7:0];

    // Split keeps the pattern in the left half and live video in the right.
    wire        in_pattern = pattern_display_enable &&
                             (!live_image_split || hcount_q < (`TPG_ACTIVE_W >> 1)); // [R1] [R10]

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_luma     <= 8'h00;
            out_chroma   <= 8'h80;
            pattern_area <= 1'b0;
        end else begin
            pattern_area <= in_pattern;
            if (in_pattern) begin
                out_luma   <= gained; // [R1]
                out_chroma <= pat_chroma;
            end else begin
                out_luma   <= live_luma; // [R1]
                out_chroma <= live_chroma;
            end
        end
    end

endmodule // tpg_test_pattern_unit

`default_nettype wire

// ### test/tpg_checker_assertions.sv
// Port checker for the test pattern unit.
`timescale 1ns/1ps
`default_nettype none
module tpg_checker (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       param_wr,
    input wire logic [7:0] param_index,
    input wire logic [7:0] param_wdata,
    input wire logic [7:0] param_rdata,
    input wire logic       line_start,
    input wire logic       frame_start,
    input wire logic       active,
    input wire logic [7:0] live_luma,
    input wire logic [7:0] live_chroma,
    input wire logic [7:0] out_luma,
    input wire logic [7:0] out_chroma,
    input wire logic       pattern_area
);
    logic [7:0] eg_q;
    logic [7:0] sel_q;
    logic [9:0] hc_q;
    logic       rdy_q;
    // The first edge after reset still shows reset outputs, so rdy_q masks it.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            eg_q  <= 8'h40;
            sel_q <= 8'h00;
            hc_q  <= 10'h000;
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= 1'b1;
            if (param_wr && param_index == 8'h24) eg_q <= param_wdata;
            if (param_wr && param_index == 8'h25) sel_q <= param_wdata;
            if (line_start || frame_start) hc_q <= 10'h000;
            else if (active) hc_q <= hc_q + 10'h001;
        end
    end
    wire       mapped = param_index >= 8'h24 && param_index <= 8'h2A && param_index != 8'h26;
    wire       en     = eg_q[3];
    wire       full_c = en && !sel_q[4] && active;
    wire       half_c = en && sel_q[4] && active;
    wire       left_c = hc_q < 10'h168;
    wire       g0_c   = en && eg_q[7:6] == 2'h0;
    wire       ramp_c = en && active && sel_q[7:5] == 3'h7 && eg_q[7:6] == 2'h1 && !sel_q[3];
    wire [7:0] hr     = hc_q[9:2];
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_wr_readback;
        param_wr && mapped ##1 $stable(param_index) |-> param_rdata == $past(param_wdata);
    endproperty
    a_wr_readback: assert property (p_wr_readback) else $error("readback differs from written byte");
    property p_unmapped;
        !mapped |-> param_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped index reads nonzero");
    property p_rd_hold;
        rdy_q && !$past(param_wr) && $stable(param_index) |-> $stable(param_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("register changed without a write");
    property p_live;
        rdy_q && !$past(en) |-> out_luma == $past(live_luma) && out_chroma == $past(live_chroma) && !pattern_area;
    endproperty
    a_live: assert property (p_live) else $error("disabled output is not live video");
    property p_full;
        rdy_q && $past(full_c) |-> pattern_area;
    endproperty
    a_full: assert property (p_full) else $error("pattern missing while enabled");
    property p_split;
        rdy_q && $past(half_c) |-> pattern_area == $past(left_c);
    endproperty
    a_split: assert property (p_split) else $error("split area boundary wrong");
    property p_gain0;
        rdy_q && $past(g0_c) && pattern_area |-> out_luma == 8'h00;
    endproperty
    a_gain0: assert property (p_gain0) else $error("gain code zero not zero");
    property p_ramp7;
        rdy_q && $past(ramp_c) && pattern_area |-> out_luma == $past(hr);
    endproperty
    a_ramp7: assert property (p_ramp7) else $error("colour code 7 ramp wrong");
    c_split: cover property (rdy_q && $past(half_c) && !pattern_area);
    c_gain0: cover property (rdy_q && $past(g0_c) && pattern_area);
    c_ramp7: cover property (rdy_q && $past(ramp_c) && pattern_area);
endmodule // tpg_checker
bind tpg_test_pattern_unit tpg_checker i_tpg_checker (.clk, .sys_rst, .param_wr, .param_index, .param_wdata,
    .param_rdata, .line_start, .frame_start, .active, .live_luma, .live_chroma, .out_luma, .out_chroma, .pattern_area);
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the test pattern unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       param_wr = 1'b0;
    logic [7:0] param_index = 8'h00;
    logic [7:0] param_wdata = 8'h00;
    logic       line_start = 1'b0;
    logic       frame_start = 1'b0;
    logic       active = 1'b0;
    logic [7:0] live_luma = 8'h00;
    logic [7:0] live_chroma = 8'h00;
    wire  [7:0] param_rdata;
    wire  [7:0] out_luma;
    wire  [7:0] out_chroma;
    wire        pattern_area;
    int         num_errors = 0;
    int         total_checks = 0;
    int         seed = 66594;
    logic [7:0] cr2 = 8'h80;
    logic [7:0] cr1 = 8'h80;
    logic [7:0] cb2 = 8'h80;
    logic [7:0] cb1 = 8'h80;
    int         nlines = 0;
    always #5 clk = ~clk;
    tpg_test_pattern_unit i_tpg_test_pattern_unit (.clk, .sys_rst, .param_wr, .param_index, .param_wdata,
        .param_rdata, .line_start, .frame_start, .active, .live_luma, .live_chroma, .out_luma, .out_chroma,
        .pattern_area);
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [7:0] exp);
        @(negedge clk);
        param_wr = 1'b1;
        param_index = idx;
        param_wdata = d;
        @(negedge clk);
        param_wr = 1'b0;
        chk("rdata", param_rdata, exp);
    endtask
    // Raster luma is the mean of the ideal CR S2 and CB S1 levels of each colour.
    function automatic int rast_mean(input logic [2:0] c);
        case (c)
            3'h0: return 8'h80;
            3'h1, 3'h2: return 8'h50;
            3'h3: return 8'h20;
            3'h4: return 8'h60;
            default: return 8'h30;
        endcase
    endfunction
    // Expected pattern luma at position p, or -1 where the bench has no model; gain saturates.
    function automatic int exp_luma(input logic [7:0] e, input logic [7:0] s, input int p);
        int m;
        m = -1;
        if (s[7:5] == 3'h7) m = (p >> 2) & 255;
        else if (s[1:0] == 2'h3) m = (cr2 + cb1) >> 1;
        else if (s[1:0] == 2'h2 && !s[2]) m = ((p % 64 == 0) != s[3]) ? 255 : 0;
        else if (s[1:0] == 2'h1 && (!s[3] || s[2])) begin
            m = rast_mean(s[7:5]);
            if (s[3]) m = (m >> 1) + (p >> 3);
        end
        if (m > 0) m = (e[7:6] == 2'h0) ? 0 : m << (e[7:6] - 2'h1);
        return (m > 255) ? 255 : m;
    endfunction
    // Expected pattern chroma: serial levels by line parity and pixel phase.
    function automatic int exp_chroma(input logic [7:0] s, input int p);
        if (s[7:5] == 3'h7 || s[1:0] == 2'h2) return 8'h80;
        if (s[1:0] != 2'h3) return -1;
        if (nlines % 2 == 1) return (p % 2 == 1) ? cb1 : cb2;
        return (p % 2 == 1) ? cr1 : cr2;
    endfunction
    task automatic levels(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
        cr2 = a;
        cr1 = b;
        cb2 = c;
        cb1 = d;
        wr(8'h27, a, a);
        wr(8'h28, b, b);
        wr(8'h29, c, c);
        wr(8'h2A, d, d);
    endtask
    task automatic line(input logic [7:0] e, input logic [7:0] s);
        logic pat;
        int   h;
        int   x;
        wr(8'h24, e, e);
        wr(8'h25, s, s);
        @(negedge clk);
        line_start = 1'b1;
        nlines++;
        @(negedge clk);
        line_start = 1'b0;
        for (h = 0; h <= 720; h++) begin
            if (h > 0) begin
                pat = e[3] && (!s[4] || h <= 360);
                chk("area", {7'h0, pattern_area}, {7'h0, pat});
                if (!pat) begin
                    chk("luma", out_luma, live_luma);
                    chk("chroma", out_chroma, live_chroma);
                end else begin
                    x = exp_luma(e, s, h - 1);
                    if (x >= 0) chk("pattern luma", out_luma, 8'(x));
                    x = exp_chroma(s, h - 1);
                    if (x >= 0) chk("pattern chroma", out_chroma, 8'(x));
                end
            end
            active = (h < 720);
            live_luma = 8'($random(seed));
            live_chroma = 8'($random(seed));
            @(negedge clk);
        end
    endtask
    initial begin
        logic [7:0] ri [7] = '{8'h24, 8'h25, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h26};
        logic [7:0] rv [7] = '{8'h40, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00};
        int         k;
        logic [7:0] r;
        repeat (10) @(negedge clk);
        // Hold and preset loading happen in the processor outside this block, before any write here.
        sys_rst = 1'b0;
        for (k = 0; k < 7; k++) begin
            param_index = ri[k];
            @(negedge clk);
            chk("reset value", param_rdata, rv[k]);
        end
        wr(8'h26, 8'h5A, 8'h00);
        @(negedge clk);
        frame_start = 1'b1;
        @(negedge clk);
        frame_start = 1'b0;
        line(8'h40, 8'h03);
        levels(8'h80, 8'h60, 8'h60, 8'h80);
        line(8'h48, 8'h0B);
        line(8'hC8, 8'h13);
        line(8'h08, 8'h03);
        line(8'h48, 8'hE0);
        line(8'h88, 8'h07);
        line(8'h48, 8'h21);
        line(8'h88, 8'h0A);
        line(8'h48, 8'h0D);
        for (k = 0; k < 8; k++) begin
            r = 8'($random(seed));
            levels(r, 8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
            line(8'($random(seed)) & 8'hC8, {r[7:2], k[1:0]});
        end
        conclude();
    end
    initial begin
        #500000;
        num_errors++;
        conclude();
    end
endmodule // tb_top
`default_nettype wire
